/* dv/pcc_host.sv */
/* Host model: register strobes and resume pulse.
   Assumes task calls from the bench. */
`timescale 1ns/1ps
module pcc_host (
  input wire logic mclk,
  output pcc_pkg::pcc_req_t req,
  output logic resume_cmd
);
  initial begin
    req = '0;
    resume_cmd = 1'b0;
  end
  // One-cycle strobe; released address and data flip
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  // Resume pulse
  task automatic resume;
    @(posedge mclk);
    #1 resume_cmd = 1'b1;
    @(posedge mclk);
    #1 resume_cmd = 1'b0;
  endtask : resume
endmodule : pcc_host

/* dv/pcc_sva.sv */
/* Port checker for pcc_power_clock.
   Assumes one mclk domain with rst_n async active low. */
`timescale 1ns/1ps
module pcc_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pcc_pkg::pcc_req_t req,
  input wire logic resume_cmd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic spi_enable,
  input wire pcc_pkg::pcc_cfg_t cfg,
  input wire logic mod_clk_tick
);
  // Access that the block must take
  wire hit = req.addr == 8'h15 && !cfg.powered_down;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Register relations
  property p_rv; req.rd && hit |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read reply");
  property p_wr; req.wr && hit && !req.wdata[3] |=> cfg.clk_src == $past(req.wdata[7:6])
    && cfg.div_code == $past(req.wdata[5:4]); endproperty
  a_wr: assert property (p_wr) else $error("fields not loaded");
  property p_bad; req.wr && hit && req.wdata[3] && req.wdata != 8'h08
    |=> $stable(cfg); endproperty
  a_bad: assert property (p_bad) else $error("bad write taken");
  property p_raw; cfg.raw_modulator_output |-> cfg.core_power_level == 2'h0; endproperty
  a_raw: assert property (p_raw) else $error("raw not low power");
  // Power-down entry and stay, serial power and no ticks while down
  property p_pdn; req.wr && hit && req.wdata == 8'h08 |=> cfg.powered_down && !spi_enable;
  endproperty
  a_pdn: assert property (p_pdn) else $error("no power-down");
  property p_hold; cfg.powered_down && !resume_cmd |=> cfg.powered_down && !rvalid;
  endproperty
  a_hold: assert property (p_hold) else $error("left power-down");
  property p_spi; spi_enable == !cfg.powered_down; endproperty
  a_spi: assert property (p_spi) else $error("serial power wrong");
  property p_tick; cfg.powered_down && $past(cfg.powered_down) |-> !mod_clk_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick while down");
  // Divide by two spacing
  property p_div; mod_clk_tick && !req.wr && cfg.div_code == 2'h3 ##1 !mod_clk_tick
    && !req.wr && cfg.div_code == 2'h3 && !cfg.powered_down |=> mod_clk_tick; endproperty
  a_div: assert property (p_div) else $error("tick spacing");
  c_pdn: cover property (cfg.powered_down ##1 !cfg.powered_down);
  c_raw: cover property (cfg.raw_modulator_output);
  c_rv: cover property (rvalid);
endmodule : pcc_sva
bind pcc_power_clock pcc_sva u_sva (.mclk(mclk), .rst_n(rst_n), .req(req),
  .resume_cmd(resume_cmd), .rdata(rdata), .rvalid(rvalid), .spi_enable(spi_enable),
  .cfg(cfg), .mod_clk_tick(mod_clk_tick));

/* dv/tb_top.sv */
/* Bench for pcc_power_clock.
   Assumes pcc_host and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  logic mclk;
  logic rst_n;
  pcc_pkg::pcc_req_t req;
  logic resume_cmd;
  logic [7:0] rdata;
  logic rvalid;
  logic spi_enable;
  pcc_pkg::pcc_cfg_t cfg;
  logic mod_clk_tick;
  int miscompares;
  int n_checks;
  int n;
  pcc_host u_host (.mclk(mclk), .req(req), .resume_cmd(resume_cmd));
  pcc_power_clock dut (.mclk(mclk), .rst_n(rst_n), .req(req), .resume_cmd(resume_cmd),
    .rdata(rdata), .rvalid(rvalid), .spi_enable(spi_enable), .cfg(cfg),
    .mod_clk_tick(mod_clk_tick));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] exp);
    u_host.xfer(1'b0, 8'h15, 8'h00);
    chk(rvalid, 8'h01);
    chk(rdata, exp);
  endtask : rd
  // Edges from one tick to the next, bounded; first lines up on a tick
  task automatic period(input logic [7:0] exp);
    n = 0;
    while (mod_clk_tick !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n < 40) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1 n++;
      end while (mod_clk_tick !== 1'b1 && n < 40);
    end
    chk(n[7:0], exp);
    if (n == 40)
      close_out();
  endtask : period
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(cfg, 8'h00);
    chk(spi_enable, 8'h01);
    rd(8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b1, 8'h15, {i[1:0], i[1:0], 2'b00, i[1:0]});
      chk(cfg, {i[1:0], i[1:0], 1'b0, (i == 1) ? 2'b00 : i[1:0], 1'b0});
      rd({i[1:0], i[1:0], 2'b00, i[1:0]});
      period(8'h10 >> i);
      period(8'h10 >> i);
    end
    u_host.xfer(1'b1, 8'h16, 8'hC3);
    u_host.xfer(1'b0, 8'h16, 8'h00);
    chk(rvalid, 8'h00);
    rd(8'hF3);
    u_host.xfer(1'b1, 8'h15, 8'h07);
    chk(cfg.core_power_level, 8'h00);
    u_host.xfer(1'b1, 8'h15, 8'h06);
    rd(8'h07);
    u_host.xfer(1'b1, 8'h15, 8'h02);
    rd(8'h03);
    chk(cfg.core_power_level, 8'h03);
    u_host.xfer(1'b1, 8'h15, 8'h09);
    rd(8'h03);
    u_host.xfer(1'b1, 8'h15, 8'h08);
    chk({cfg.powered_down, spi_enable}, 8'h02);
    u_host.xfer(1'b0, 8'h15, 8'h00);
    chk(rvalid, 8'h00);
    u_host.xfer(1'b1, 8'h15, 8'h40);
    u_host.resume();
    rd(8'h00);
    u_host.xfer(1'b1, 8'h15, 8'h08);
    rst_n = 1'b0;
    @(posedge mclk);
    #1 rst_n = 1'b1;
    chk(cfg, 8'h00);
    chk(spi_enable, 8'h01);
    rd(8'h00);
    close_out();
  end
endmodule : tb_top

/* pkg/pcc_pkg.sv */
/*
  Package for the power and clock control block: register address, field
  positions, reset value and enumerations. Assumes a single 8-bit register
  written and read by an upstream serial interface decoder.
*/
package pcc_pkg;
  // Register address and reset value
  localparam logic [7:0] PCC_ADDR = 8'h15;
  localparam logic [7:0] PCC_RESET_VAL = 8'h00;
  localparam logic [7:0] PCC_PDN_VAL = 8'h08;
  // Field positions
  localparam int PCC_CLKSEL_HI = 7;
  localparam int PCC_CLKSEL_LO = 6;
  localparam int PCC_DIV_HI = 5;
  localparam int PCC_DIV_LO = 4;
  localparam int PCC_PDN_BIT = 3;
  localparam int PCC_RAW_BIT = 2;
  localparam int PCC_PWR_HI = 1;
  localparam int PCC_PWR_LO = 0;
  // Divider ratios per code
  localparam logic [4:0] PCC_DIV16 = 5'h10;
  localparam logic [4:0] PCC_DIV8 = 5'h08;
  localparam logic [4:0] PCC_DIV4 = 5'h04;
  localparam logic [4:0] PCC_DIV2 = 5'h02;

  typedef enum logic [1:0] {
    PCC_CLK_CMOS = 2'h0,
    PCC_CLK_XTAL = 2'h1,
    PCC_CLK_LVDS = 2'h2,
    PCC_CLK_RC = 2'h3
  } pcc_clk_src_t;

  typedef enum logic [1:0] {
    PCC_PWR_LOW = 2'h0,
    PCC_PWR_UNDEF = 2'h1,
    PCC_PWR_MEDIAN = 2'h2,
    PCC_PWR_FAST = 2'h3
  } pcc_pwr_t;

  // Gray-coded power state
  typedef enum logic [0:0] {
    PCC_ST_ON = 1'b0,
    PCC_ST_DOWN = 1'b1
  } pcc_state_t;

  // Register write and read request from the serial decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcc_req_t;

  // Decoded configuration driven into the core
  typedef struct packed {
    pcc_clk_src_t clk_src;
    logic [1:0] div_code;
    logic raw_modulator_output;
    pcc_pwr_t core_power_level;
    logic powered_down;
  } pcc_cfg_t;
endpackage : pcc_pkg

/* src/pcc_mod_div.sv */
/*
  Modulator clock divider: a free counter producing a one-cycle tick every
  ratio cycles of mclk. Assumes the ratio is stable or changes only rarely.
*/
`timescale 1ns/1ps
module pcc_mod_div #(
  parameter int CW = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [CW-1:0] ratio,
  output logic tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } pcc_div_st_t;

  pcc_div_st_t st_r;
  pcc_div_st_t st_nxt;

  // Count up to ratio-1, then wrap and pulse
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= ratio - CW'(1)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : pcc_mod_div

/* src/pcc_power_clock.sv */
/*
  Power and clock control register with power-down sequencing and the
  modulator clock divider.
  Holds the register, decides which writes are taken, tracks the power
  state and decodes the stored fields into a configuration word.
  Assumes an upstream serial decoder that presents single-cycle write and
  read strobes, and a separate resume command detector that stays alive
  while the device is powered down. A power cycle reaches this logic as
  a reset. Reads return the stored power field, not the forced level, and
  an undefined power code is reported to the core as low power.
*/
// Behaviour
// - Register sits at address 0x15, resets to all zeros.
// - Bits 7:6 choose CMOS, crystal, LVDS or internal RC clock.
// - Bits 5:4 divide master clock by 16, 8, 4 or 2.
// - Write with bit 3 and any other bit set is discarded entirely.
// - Powered down: all blocks and serial interface shut off.
// - Power-down left only by reset, resume command, or power cycle.
// - Raw modulator output forces low power, ignores power field writes.
// - Bits 1:0 select low, median or fast core power level.
`timescale 1ns/1ps
module pcc_power_clock (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pcc_pkg::pcc_req_t req,
  input wire logic resume_cmd,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic spi_enable,
  output pcc_pkg::pcc_cfg_t cfg,
  output logic mod_clk_tick
);
  typedef struct packed {
    logic [7:0] reg_val;
    pcc_pkg::pcc_state_t state;
    logic [7:0] rdata;
    logic rvalid;
    pcc_pkg::pcc_cfg_t cfg;
    logic spi_enable;
    logic tick;
  } pcc_st_t;

  pcc_st_t st_r;
  pcc_st_t st_nxt;
  logic [4:0] ratio;
  logic div_tick;
  // Divider enable
  logic div_run;
  // Request decode
  logic hit_wr;
  logic hit_rd;
  logic pdn_set;
  logic pdn_req;
  logic plain_wr;
  logic wr_take;
  logic rd_take;
  logic resume_take;
  logic raw_lock;
  // Next register, power state, read data and configuration
  logic [7:0] wr_val;
  logic [7:0] wv;
  logic [7:0] rdata_nxt;
  pcc_pkg::pcc_state_t state_nxt;
  pcc_pkg::pcc_cfg_t cfg_nxt;

  // Divider ratio from the divider field
  always_comb begin
    case (st_r.reg_val[pcc_pkg::PCC_DIV_HI:pcc_pkg::PCC_DIV_LO])
      2'h0: ratio = pcc_pkg::PCC_DIV16;
      2'h1: ratio = pcc_pkg::PCC_DIV8;
      2'h2: ratio = pcc_pkg::PCC_DIV4;
      2'h3: ratio = pcc_pkg::PCC_DIV2;
      default: ratio = pcc_pkg::PCC_DIV16;
    endcase
  end

  // Divider runs only while on; stopping it also restarts its phase on resume
  assign div_run = (st_r.state == pcc_pkg::PCC_ST_ON);

  // Divider is stopped while powered down
  pcc_mod_div #(
    .CW(5)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(div_run),
    .ratio(ratio),
    .tick(div_tick)
  );

  // Classify the request of this cycle; an address miss is simply not seen
  always_comb begin
    hit_wr = req.wr && (req.addr == pcc_pkg::PCC_ADDR);
    hit_rd = req.rd && (req.addr == pcc_pkg::PCC_ADDR);
    pdn_set = req.wdata[pcc_pkg::PCC_PDN_BIT];
    // Only the exact power-down value may carry bit 3
    pdn_req = hit_wr && (req.wdata == pcc_pkg::PCC_PDN_VAL);
    // Bit 3 with any other bit is neither kind, so that write is dropped whole
    plain_wr = hit_wr && !pdn_set;
    wr_take = pdn_req || plain_wr;
    resume_take = resume_cmd && (st_r.state == pcc_pkg::PCC_ST_DOWN);
    raw_lock = st_r.reg_val[pcc_pkg::PCC_RAW_BIT];
  end

  // Value a taken write leaves behind
  always_comb begin
    wr_val = req.wdata;
    // The stored raw bit locks the power field; the write that sets raw is not locked
    if (raw_lock) begin
      wr_val[pcc_pkg::PCC_PWR_HI:pcc_pkg::PCC_PWR_LO] =
        st_r.reg_val[pcc_pkg::PCC_PWR_HI:pcc_pkg::PCC_PWR_LO];
    end
  end

  // Power state: once down, only reset or the resume command bring it back
  always_comb begin
    state_nxt = st_r.state;
    case (st_r.state)
      pcc_pkg::PCC_ST_ON: begin
        // Exact power-down write is the only way down
        if (pdn_req) begin
          state_nxt = pcc_pkg::PCC_ST_DOWN;
        end
      end
      pcc_pkg::PCC_ST_DOWN: begin
        // Serial traffic is ignored here; the resume detector stays alive
        if (resume_take) begin
          state_nxt = pcc_pkg::PCC_ST_ON;
        end
      end
      default: begin
        state_nxt = pcc_pkg::PCC_ST_ON;
      end
    endcase
  end

  // Register contents: writes land only while on; resume clears the power-down bit
  always_comb begin
    wv = st_r.reg_val;
    // Writes that arrive while down are lost, not queued
    if ((st_r.state == pcc_pkg::PCC_ST_ON) && wr_take) begin
      wv = wr_val;
    end else if (resume_take) begin
      wv[pcc_pkg::PCC_PDN_BIT] = 1'b0;
    end
  end

  // Reads are answered only while on
  assign rd_take = hit_rd && (st_r.state == pcc_pkg::PCC_ST_ON);

  // Read data holds until the next answered read
  always_comb begin
    rdata_nxt = st_r.rdata;
    if (rd_take) begin
      rdata_nxt = st_r.reg_val;
    end
  end

  // Power level the core runs at; raw output overrides the stored field
  function automatic pcc_pkg::pcc_pwr_t pcc_eff_pwr(input logic [7:0] v);
    pcc_pkg::pcc_pwr_t lvl;
    if (v[pcc_pkg::PCC_RAW_BIT]) begin
      lvl = pcc_pkg::PCC_PWR_LOW;
    end else begin
      case (v[pcc_pkg::PCC_PWR_HI:pcc_pkg::PCC_PWR_LO])
        2'h0: lvl = pcc_pkg::PCC_PWR_LOW;
        2'h1: lvl = pcc_pkg::PCC_PWR_LOW;
        2'h2: lvl = pcc_pkg::PCC_PWR_MEDIAN;
        2'h3: lvl = pcc_pkg::PCC_PWR_FAST;
        default: lvl = pcc_pkg::PCC_PWR_LOW;
      endcase
    end
    return lvl;
  endfunction : pcc_eff_pwr

  // Field decode into the configuration word for the core
  always_comb begin
    cfg_nxt = '0;
    case (wv[pcc_pkg::PCC_CLKSEL_HI:pcc_pkg::PCC_CLKSEL_LO])
      2'h0: cfg_nxt.clk_src = pcc_pkg::PCC_CLK_CMOS;
      2'h1: cfg_nxt.clk_src = pcc_pkg::PCC_CLK_XTAL;
      2'h2: cfg_nxt.clk_src = pcc_pkg::PCC_CLK_LVDS;
      2'h3: cfg_nxt.clk_src = pcc_pkg::PCC_CLK_RC;
      default: cfg_nxt.clk_src = pcc_pkg::PCC_CLK_CMOS;
    endcase
    cfg_nxt.div_code = wv[pcc_pkg::PCC_DIV_HI:pcc_pkg::PCC_DIV_LO];
    cfg_nxt.raw_modulator_output = wv[pcc_pkg::PCC_RAW_BIT];
    cfg_nxt.core_power_level = pcc_eff_pwr(wv);
    cfg_nxt.powered_down = (state_nxt == pcc_pkg::PCC_ST_DOWN);
  end

  // Next copy of the whole state
  always_comb begin
    st_nxt = st_r;
    st_nxt.reg_val = wv;
    st_nxt.state = state_nxt;
    // Valid is a single-cycle pulse beside the held read data
    st_nxt.rvalid = rd_take;
    st_nxt.rdata = rdata_nxt;
    st_nxt.cfg = cfg_nxt;
    st_nxt.spi_enable = (state_nxt == pcc_pkg::PCC_ST_ON);
    // Gate with the next state so no stray tick leaks into power-down
    st_nxt.tick = div_tick && (state_nxt == pcc_pkg::PCC_ST_ON);
  end

  // State register; reset pin also ends power-down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.reg_val <= pcc_pkg::PCC_RESET_VAL;
      st_r.state <= pcc_pkg::PCC_ST_ON;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.cfg <= '0;
      st_r.spi_enable <= 1'b1;
      st_r.tick <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;
  assign spi_enable = st_r.spi_enable;
  assign cfg = st_r.cfg;
  assign mod_clk_tick = st_r.tick;
endmodule : pcc_power_clock
